// File: design/ata_pin_map.svh
// Address map, field positions and reset values of the ATA host pin port
`ifndef ATA_PIN_MAP_SVH
`define ATA_PIN_MAP_SVH

`define TF_DATA        3'h0
`define TF_ERROR       3'h1
`define TF_COUNT       3'h2
`define TF_LBA_LOW     3'h3
`define TF_LBA_MID     3'h4
`define TF_LBA_HIGH    3'h5
`define TF_DEVICE      3'h6
`define TF_STATUS      3'h7
`define TF_ALT_STATUS  3'h6

`define DEV_SEL_BIT    4
`define NIEN_BIT       1
`define SRST_BIT       2

`define TF_RESET       8'h00
`define DEVCTL_RESET   8'h00

`define CFG_BASE       10'h200
`define CFG_COUNT      4
`define CFG_RESET      8'h00

`endif

// File: design/ata_pin_pkg.sv
// Types shared by the ATA host pin port modules
package ata_pin_pkg;
	typedef logic [2:0]  tf_addr_t;
	typedef logic [7:0]  tf_byte_t;
	typedef logic [15:0] tf_word_t;
	typedef enum logic { BUS_IDLE, BUS_DRIVE } bus_state_e;
endpackage

// File: design/task_file_regs.sv
// Byte-wide task file registers and device control register
`timescale 1ns/10ps
`include "ata_pin_map.svh"
module task_file_regs
(
	input  wire logic                  clk_in,
	input  wire logic                  reset_n_in,
	input  wire logic                  ce_in,
	input  wire logic                  wr_en_in,
	input  wire logic                  wr_cs1_in,
	input  wire ata_pin_pkg::tf_addr_t wr_addr_in,
	input  wire ata_pin_pkg::tf_byte_t wr_data_in,
	input  wire ata_pin_pkg::tf_addr_t rd_addr_in,
	input  wire ata_pin_pkg::tf_byte_t error_in,
	output ata_pin_pkg::tf_byte_t      rd_data_out,
	output logic                       dev_sel_out,
	output logic                       nien_out,
	output logic                       srst_out
);
	import ata_pin_pkg::*;

	tf_byte_t regs_q [1:6];
	tf_byte_t regs_d [1:6];
	tf_byte_t devctl_q;
	tf_byte_t devctl_d;

	always_comb
	begin
		regs_d   = regs_q;
		devctl_d = devctl_q;
		if (wr_en_in && wr_cs1_in && wr_addr_in == `TF_ALT_STATUS)
			devctl_d = wr_data_in;
		else if (wr_en_in && !wr_cs1_in && wr_addr_in != `TF_DATA
			&& wr_addr_in != `TF_STATUS)
			regs_d[wr_addr_in] = wr_data_in;
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			for (int i = 1; i <= 6; i++)
				regs_q[i] <= `TF_RESET;
			devctl_q <= `DEVCTL_RESET;
		end
		else if (ce_in)
		begin
			regs_q   <= regs_d;
			devctl_q <= devctl_d;
		end
	end

	// Error reads back core state; the feature byte written there is kept
	always_comb
	begin
		unique case (rd_addr_in)
			`TF_ERROR:                     rd_data_out = error_in;
			`TF_COUNT, `TF_LBA_LOW,
			`TF_LBA_MID, `TF_LBA_HIGH,
			`TF_DEVICE:                    rd_data_out = regs_q[rd_addr_in];
			default:                       rd_data_out = 8'h00;
		endcase
	end

	assign dev_sel_out = regs_q[`TF_DEVICE][`DEV_SEL_BIT];
	assign nien_out    = devctl_q[`NIEN_BIT];
	assign srst_out    = devctl_q[`SRST_BIT];
endmodule

// File: design/ata_host_pin_interface.sv
// Drive-side ATA host pin port: strobes, bus drive, interrupt and config space
`timescale 1ns/10ps
`include "ata_pin_map.svh"
// Overview of operation
// - Host writes are captured on the rising edge of the write strobe.
// - Drive places data or status on bus while read strobe is low.
// - Data moves 16 bits wide; commands and byte registers use low 8 lines.
// - Host drives inputs, drive drives outputs, data lines follow direction.
// - Primary or secondary role comes from the jumper; respond only when addressed.
// - Configuration registers sit in attribute space starting at 200h.
// - Three address lines pick one of eight task file registers per access.
// - First select reaches task file; second reaches alternate status and control.
// - Active-high interrupt request goes to the host when service is needed.
module ata_host_pin_interface
(
	input  wire logic                  clk_in,
	input  wire logic                  reset_n_in,
	input  wire logic                  ce_in,
	input  wire logic                  iow_n_in,
	input  wire logic                  ior_n_in,
	input  wire logic                  cs0_n_in,
	input  wire logic                  cs1_n_in,
	input  wire ata_pin_pkg::tf_addr_t addr_in,
	input  wire ata_pin_pkg::tf_word_t data_in,
	output ata_pin_pkg::tf_word_t      data_out,
	output logic                       data_oe_n_out,
	output logic                       intrq_out,
	input  wire logic                  csel_n_in,
	input  wire ata_pin_pkg::tf_word_t core_rd_data_in,
	input  wire ata_pin_pkg::tf_byte_t core_status_in,
	input  wire ata_pin_pkg::tf_byte_t core_error_in,
	input  wire logic                  core_irq_in,
	output logic                       data_wr_pulse_out,
	output ata_pin_pkg::tf_word_t      data_wr_word_out,
	output logic                       data_rd_pulse_out,
	output logic                       cmd_pulse_out,
	output ata_pin_pkg::tf_byte_t      cmd_out,
	output logic                       soft_reset_out,
	output logic                       secondary_out,
	input  wire logic                  cfg_sel_in,
	input  wire logic                  cfg_wr_in,
	input  wire logic [9:0]            cfg_addr_in,
	input  wire ata_pin_pkg::tf_byte_t cfg_wdata_in,
	output ata_pin_pkg::tf_byte_t      cfg_rdata_out
);
	import ata_pin_pkg::*;

	// Decoded access: one select low, other high
	function automatic logic one_select(input logic cs0_n, input logic cs1_n);
		return cs0_n ^ cs1_n;
	endfunction

	function automatic logic cfg_hit(input logic [9:0] a);
		return a[9:3] == 7'(`CFG_BASE >> 3) && !a[0];
	endfunction

	logic       iow_prev_q, ior_prev_q;
	logic       wr_cs1_q, wr_cs1_d, wr_ok_q, wr_ok_d;
	tf_addr_t   wr_addr_q, wr_addr_d;
	tf_word_t   wr_data_q, wr_data_d;
	logic       rd_cs1_q, rd_cs1_d, rd_ok_q, rd_ok_d;
	tf_addr_t   rd_addr_q, rd_addr_d;
	logic       role_valid_q, role_valid_d, secondary_q, secondary_d;
	logic       iow_rise, ior_rise, dev_match, tf_wr_en;
	tf_byte_t   tf_rd_byte;
	logic       dev_sel, nien, srst;
	bus_state_e bus_d;
	logic       oe_n_q, oe_n_d;
	tf_word_t   data_q, data_d;
	logic       pend_q, pend_d, intrq_q, intrq_d;
	logic       dwr_q, dwr_d, drd_q, drd_d, cmdp_q, cmdp_d;
	tf_word_t   dword_q, dword_d;
	tf_byte_t   cmd_q, cmd_d;
	tf_byte_t   cfg_q [`CFG_COUNT];
	tf_byte_t   cfg_d [`CFG_COUNT];
	tf_byte_t   cfg_rd_q, cfg_rd_d;

	assign iow_rise  = !iow_prev_q && iow_n_in;
	assign ior_rise  = !ior_prev_q && ior_n_in;
	assign dev_match = role_valid_q && (dev_sel == secondary_q);
	// Device register and control are shared; both drives latch them
	assign tf_wr_en  = iow_rise && wr_ok_q
		&& (dev_match || wr_addr_q == `TF_DEVICE);

	task_file_regs u_regs
	(
		.clk_in      (clk_in),
		.reset_n_in  (reset_n_in),
		.ce_in       (ce_in),
		.wr_en_in    (tf_wr_en),
		.wr_cs1_in   (wr_cs1_q),
		.wr_addr_in  (wr_addr_q),
		.wr_data_in  (wr_data_q[7:0]),
		.rd_addr_in  (addr_in),
		.error_in    (core_error_in),
		.rd_data_out (tf_rd_byte),
		.dev_sel_out (dev_sel),
		.nien_out    (nien),
		.srst_out    (srst)
	);

	// Address, select and data held while strobes are low; edge uses last held
	always_comb
	begin
		wr_cs1_d  = wr_cs1_q;
		wr_addr_d = wr_addr_q;
		wr_data_d = wr_data_q;
		wr_ok_d   = wr_ok_q;
		rd_cs1_d  = rd_cs1_q;
		rd_addr_d = rd_addr_q;
		rd_ok_d   = rd_ok_q;
		if (!iow_n_in)
		begin
			wr_cs1_d  = !cs1_n_in;
			wr_addr_d = addr_in;
			wr_data_d = data_in;
			wr_ok_d   = one_select(cs0_n_in, cs1_n_in);
		end
		if (!ior_n_in)
		begin
			rd_cs1_d  = !cs1_n_in;
			rd_addr_d = addr_in;
			rd_ok_d   = one_select(cs0_n_in, cs1_n_in) && dev_match;
		end
		// Strap is sampled once after reset release, never inside the reset
		role_valid_d = 1'b1;
		secondary_d  = role_valid_q ? secondary_q : csel_n_in;
	end

	// Read path; registered, so the bus follows the strobe one cycle late
	always_comb
	begin
		bus_d  = BUS_IDLE;
		data_d = 16'h0000;
		if (!ior_n_in && one_select(cs0_n_in, cs1_n_in) && dev_match)
		begin
			bus_d = BUS_DRIVE;
			if (!cs1_n_in)
				data_d = {8'h00, addr_in == `TF_ALT_STATUS ? core_status_in : 8'h00};
			else if (addr_in == `TF_DATA)
				data_d = core_rd_data_in;
			else if (addr_in == `TF_STATUS)
				data_d = {8'h00, core_status_in};
			else
				data_d = {8'h00, tf_rd_byte};
		end
		// Enable kept in its own flop so the pin needs no gate after it
		oe_n_d = bus_d != BUS_DRIVE;
	end

	// Pending request: a new event wins over a clear in the same cycle
	always_comb
	begin
		logic clr;
		clr = 1'b0;
		if (srst || (ior_rise && rd_ok_q && !rd_cs1_q && rd_addr_q == `TF_STATUS))
			clr = 1'b1;
		pend_d  = core_irq_in || (pend_q && !clr);
		intrq_d = pend_q && !nien && dev_match;
	end

	// Strobes toward the core, one cycle wide
	always_comb
	begin
		dwr_d   = tf_wr_en && !wr_cs1_q && wr_addr_q == `TF_DATA;
		dword_d = dwr_d ? wr_data_q : dword_q;
		cmdp_d  = tf_wr_en && !wr_cs1_q && wr_addr_q == `TF_STATUS;
		cmd_d   = cmdp_d ? wr_data_q[7:0] : cmd_q;
		drd_d   = ior_rise && rd_ok_q && !rd_cs1_q && rd_addr_q == `TF_DATA;
	end

	// Config space; core side reaches it, no host pin path here
	always_comb
	begin
		cfg_d    = cfg_q;
		cfg_rd_d = cfg_rd_q;
		if (cfg_sel_in && cfg_hit(cfg_addr_in))
		begin
			if (cfg_wr_in)
				cfg_d[cfg_addr_in[2:1]] = cfg_wdata_in;
			else
				cfg_rd_d = cfg_q[cfg_addr_in[2:1]];
		end
		else if (cfg_sel_in && !cfg_wr_in)
			cfg_rd_d = 8'h00;
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			iow_prev_q   <= 1'b1;
			ior_prev_q   <= 1'b1;
			wr_cs1_q     <= 1'b0;
			wr_addr_q    <= 3'h0;
			wr_data_q    <= 16'h0000;
			wr_ok_q      <= 1'b0;
			rd_cs1_q     <= 1'b0;
			rd_addr_q    <= 3'h0;
			rd_ok_q      <= 1'b0;
			role_valid_q <= 1'b0;
			secondary_q  <= 1'b0;
			oe_n_q       <= 1'b1;
			data_q       <= 16'h0000;
			pend_q       <= 1'b0;
			intrq_q      <= 1'b0;
			dwr_q        <= 1'b0;
			dword_q      <= 16'h0000;
			drd_q        <= 1'b0;
			cmdp_q       <= 1'b0;
			cmd_q        <= 8'h00;
			cfg_rd_q     <= 8'h00;
			for (int i = 0; i < `CFG_COUNT; i++)
				cfg_q[i] <= `CFG_RESET;
		end
		else if (ce_in)
		begin
			iow_prev_q   <= iow_n_in;
			ior_prev_q   <= ior_n_in;
			wr_cs1_q     <= wr_cs1_d;
			wr_addr_q    <= wr_addr_d;
			wr_data_q    <= wr_data_d;
			wr_ok_q      <= wr_ok_d;
			rd_cs1_q     <= rd_cs1_d;
			rd_addr_q    <= rd_addr_d;
			rd_ok_q      <= rd_ok_d;
			role_valid_q <= role_valid_d;
			secondary_q  <= secondary_d;
			oe_n_q       <= oe_n_d;
			data_q       <= data_d;
			pend_q       <= pend_d;
			intrq_q      <= intrq_d;
			dwr_q        <= dwr_d;
			dword_q      <= dword_d;
			drd_q        <= drd_d;
			cmdp_q       <= cmdp_d;
			cmd_q        <= cmd_d;
			cfg_rd_q     <= cfg_rd_d;
			cfg_q        <= cfg_d;
		end
	end

	assign data_out          = data_q;
	assign data_oe_n_out     = oe_n_q;
	assign intrq_out         = intrq_q;
	assign data_wr_pulse_out = dwr_q;
	assign data_wr_word_out  = dword_q;
	assign data_rd_pulse_out = drd_q;
	assign cmd_pulse_out     = cmdp_q;
	assign cmd_out           = cmd_q;
	assign soft_reset_out    = srst;
	assign secondary_out     = secondary_q;
	assign cfg_rdata_out     = cfg_rd_q;

	cmd_capture_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		ce_in && tf_wr_en && !wr_cs1_q && wr_addr_q == `TF_STATUS
		|=> cmdp_q && cmd_q == $past(wr_data_q[7:0]))
		else $error("command not captured on write strobe rise");
	data_capture_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		ce_in && iow_rise && wr_ok_q && !wr_cs1_q && wr_addr_q == `TF_DATA && dev_match
		|=> dwr_q && dword_q == $past(wr_data_q))
		else $error("data word not captured");
	read_drive_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		ce_in && !ior_n_in && !cs0_n_in && cs1_n_in && dev_match && addr_in == `TF_STATUS
		|=> !data_oe_n_out && data_out == {8'h00, $past(core_status_in)})
		else $error("status not driven during read strobe");
	bus_release_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		ce_in && (ior_n_in || cs0_n_in == cs1_n_in) |=> data_oe_n_out)
		else $error("bus driven while not read");
	byte_lane_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		ce_in && !ior_n_in && addr_in != `TF_DATA |=> data_out[15:8] == 8'h00)
		else $error("byte register on upper lines");
	role_match_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		ce_in && !dev_match |=> data_oe_n_out && !intrq_out)
		else $error("answered while not addressed");
	cs1_no_cmd_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		ce_in && iow_rise && wr_cs1_q |=> !cmdp_q && !dwr_q)
		else $error("second select reached task file");
	cfg_base_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		ce_in && cfg_sel_in && !cfg_wr_in && cfg_addr_in == `CFG_BASE
		|=> cfg_rdata_out == $past(cfg_q[0]))
		else $error("config base not at 200h");
	irq_raise_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		ce_in && core_irq_in ##1 ce_in && !nien && dev_match |=> intrq_out)
		else $error("interrupt request not raised");
endmodule

// File: testbench/ata_host_model.sv
// Host controller model: strobes, selects, address and the shared data bus
`timescale 1ns/10ps
module ata_host_model
(
	input  wire logic                  clk_in,
	input  wire ata_pin_pkg::tf_word_t dev_data_in,
	input  wire logic                  dev_oe_n_in,
	output logic                       iow_n_out,
	output logic                       ior_n_out,
	output logic                       cs0_n_out,
	output logic                       cs1_n_out,
	output ata_pin_pkg::tf_addr_t      addr_out,
	output ata_pin_pkg::tf_word_t      bus_out
);
	import ata_pin_pkg::*;
	logic     host_oe;
	tf_word_t host_val;
	tf_word_t last_q;
	// No pull on the data lines, so an undriven bus shows the inverse of its last value
	assign bus_out = !dev_oe_n_in ? dev_data_in : host_oe ? host_val : ~last_q;
	// Only a driven bus updates the remembered level, so a float does not toggle
	always @(posedge clk_in)
		if (!dev_oe_n_in || host_oe)
			last_q <= bus_out;
	initial
	begin
		{iow_n_out, ior_n_out, cs0_n_out, cs1_n_out} = 4'hf;
		addr_out = 3'h0;
		host_oe = 1'b0;
		host_val = 16'h0000;
		last_q = 16'h0000;
	end
	// One select, address and word held across the whole strobe
	task automatic wr(input logic sel1, input tf_addr_t a, input tf_word_t w);
		@(negedge clk_in);
		cs0_n_out = sel1;
		cs1_n_out = !sel1;
		addr_out = a;
		host_val = w;
		host_oe = 1'b1;
		iow_n_out = 1'b0;
		@(negedge clk_in);
		iow_n_out = 1'b1;
		@(negedge clk_in);
		{cs0_n_out, cs1_n_out, host_oe} = 3'h6;
	endtask
	task automatic rd(input logic sel1, input tf_addr_t a, output tf_word_t w, output logic seen);
		@(negedge clk_in);
		cs0_n_out = sel1;
		cs1_n_out = !sel1;
		addr_out = a;
		ior_n_out = 1'b0;
		seen = 1'b0;
		repeat (3)
		begin
			@(negedge clk_in);
			if (dev_oe_n_in === 1'b0)
				seen = 1'b1;
		end
		w = bus_out;
		ior_n_out = 1'b1;
		@(negedge clk_in);
		{cs0_n_out, cs1_n_out} = 2'h3;
	endtask
endmodule

// File: testbench/ata_host_pin_interface_tb.sv
// Self-checking bench for the drive-side ATA host pin port
`timescale 1ns/10ps
`include "ata_pin_map.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module ata_host_pin_interface_tb;
	import ata_pin_pkg::*;
	logic     clk, reset_n, iow_n, ior_n, cs0_n, cs1_n, oe_n, intrq, csel_n, irq;
	logic     dwr, drd, cmdp, srst, sec, cfg_sel, cfg_wr, ce;
	tf_addr_t addr;
	tf_word_t bus, dout, rdw, wword, w;
	tf_byte_t status, error, cmd, cfg_wd, cfg_rd;
	logic [9:0] cfg_a;
	logic     seen;
	int       fails = 0, checks_done = 0, n_dwr = 0, n_drd = 0, n_cmd = 0, cyc = 0;
	ata_host_pin_interface dut_u (.clk_in(clk), .reset_n_in(reset_n), .ce_in(ce),
		.iow_n_in(iow_n), .ior_n_in(ior_n), .cs0_n_in(cs0_n), .cs1_n_in(cs1_n),
		.addr_in(addr), .data_in(bus), .data_out(dout), .data_oe_n_out(oe_n),
		.intrq_out(intrq), .csel_n_in(csel_n), .core_rd_data_in(rdw),
		.core_status_in(status), .core_error_in(error), .core_irq_in(irq),
		.data_wr_pulse_out(dwr), .data_wr_word_out(wword), .data_rd_pulse_out(drd),
		.cmd_pulse_out(cmdp), .cmd_out(cmd), .soft_reset_out(srst), .secondary_out(sec),
		.cfg_sel_in(cfg_sel), .cfg_wr_in(cfg_wr), .cfg_addr_in(cfg_a),
		.cfg_wdata_in(cfg_wd), .cfg_rdata_out(cfg_rd));
	ata_host_model host_u (.clk_in(clk), .dev_data_in(dout), .dev_oe_n_in(oe_n),
		.iow_n_out(iow_n), .ior_n_out(ior_n), .cs0_n_out(cs0_n), .cs1_n_out(cs1_n),
		.addr_out(addr), .bus_out(bus));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Pulse counters catch both missing and doubled pulses; falling edge sees them settled
	always @(negedge clk)
	begin
		cyc++;
		n_dwr += (dwr === 1'b1);
		n_drd += (drd === 1'b1);
		n_cmd += (cmdp === 1'b1);
		if (cyc == 3000)
		begin
			fails++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("checks_done %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic do_reset(input logic role);
		csel_n = role;
		reset_n = 1'b0;
		repeat (5) @(negedge clk);
		`CHK("oe_n_rst", 1'b1, oe_n)
		`CHK("intrq_rst", 1'b0, intrq)
		`CHK("cfg_rst", 8'h00, cfg_rd)
		reset_n = 1'b1;
		repeat (3) @(negedge clk);
		`CHK("role", role, sec)
	endtask
	task automatic rdc(input logic s1, input tf_addr_t a, input tf_word_t e);
		host_u.rd(s1, a, w, seen);
		`CHK("rd_seen", 1'b1, seen)
		`CHK("rd_word", e, w)
		@(negedge clk);
		`CHK("released", 1'b1, oe_n)
	endtask
	task automatic t_write();
		host_u.wr(1'b0, `TF_DATA, 16'ha55a);
		host_u.wr(1'b0, `TF_STATUS, 16'h12ec);
		repeat (3) @(negedge clk);
		`CHK("dwr_cnt", 1, n_dwr)
		`CHK("wr_word", 16'ha55a, wword)
		`CHK("cmd_cnt", 1, n_cmd)
		`CHK("cmd", 8'hec, cmd)
		$display("done t_write");
	endtask
	task automatic t_read();
		rdc(1'b0, `TF_STATUS, 16'h005a);
		rdc(1'b0, `TF_DATA, 16'hbeef);
		`CHK("drd_cnt", 1, n_drd)
		// Byte register keeps only the low lines of the word
		host_u.wr(1'b0, `TF_COUNT, 16'h7733);
		rdc(1'b0, `TF_COUNT, 16'h0033);
		rdc(1'b0, `TF_ERROR, 16'h0004);
		rdc(1'b1, `TF_ALT_STATUS, 16'h005a);
		rdc(1'b1, 3'h0, 16'h0000);
		$display("done t_read");
	endtask
	task automatic irq_pulse();
		@(negedge clk) irq = 1'b1;
		@(negedge clk) irq = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	task automatic t_irq();
		irq_pulse();
		`CHK("intrq_set", 1'b1, intrq)
		rdc(1'b0, `TF_STATUS, 16'h005a);
		`CHK("intrq_clr", 1'b0, intrq)
		host_u.wr(1'b1, `TF_ALT_STATUS, 16'h0002);
		irq_pulse();
		`CHK("intrq_mask", 1'b0, intrq)
		host_u.wr(1'b1, `TF_ALT_STATUS, 16'h0000);
		repeat (3) @(negedge clk);
		`CHK("intrq_unmask", 1'b1, intrq)
		host_u.wr(1'b1, `TF_ALT_STATUS, 16'h0004);
		repeat (3) @(negedge clk);
		`CHK("srst", 1'b1, srst)
		`CHK("intrq_srst", 1'b0, intrq)
		host_u.wr(1'b1, `TF_ALT_STATUS, 16'h0000);
		repeat (3) @(negedge clk);
		`CHK("srst_off", 1'b0, srst)
		$display("done t_irq");
	endtask
	// Enable low: neither a write strobe nor a service request may leave a trace
	task automatic t_ce();
		@(negedge clk) ce = 1'b0;
		irq_pulse();
		host_u.wr(1'b0, `TF_DATA, 16'h1234);
		@(negedge clk) ce = 1'b1;
		repeat (3) @(negedge clk);
		`CHK("ce_dwr", 1, n_dwr)
		`CHK("ce_word", 16'ha55a, wword)
		`CHK("ce_intrq", 1'b0, intrq)
		$display("done t_ce");
	endtask
	task automatic t_role();
		do_reset(1'b1);
		host_u.rd(1'b0, `TF_STATUS, w, seen);
		`CHK("other_dev", 1'b0, seen)
		host_u.wr(1'b0, `TF_DEVICE, 16'h0010);
		rdc(1'b0, `TF_STATUS, 16'h005a);
		$display("done t_role");
	endtask
	task automatic cfg(input logic wr, input logic [9:0] a, input tf_byte_t d);
		@(negedge clk);
		{cfg_sel, cfg_wr, cfg_a, cfg_wd} = {1'b1, wr, a, d};
		@(negedge clk) cfg_sel = 1'b0;
		@(negedge clk);
	endtask
	task automatic t_cfg();
		cfg(1'b1, `CFG_BASE, 8'h3c);
		cfg(1'b1, 10'h206, 8'hc3);
		cfg(1'b0, `CFG_BASE, 8'h00);
		`CHK("cfg200", 8'h3c, cfg_rd)
		cfg(1'b0, 10'h206, 8'h00);
		`CHK("cfg206", 8'hc3, cfg_rd)
		cfg(1'b0, 10'h201, 8'h00);
		`CHK("cfg201", 8'h00, cfg_rd)
		$display("done t_cfg");
	endtask
	initial
	begin
		{irq, cfg_sel, cfg_wr, cfg_a, cfg_wd} = '0;
		ce = 1'b1;
		{status, error, rdw} = {8'h5a, 8'h04, 16'hbeef};
		do_reset(1'b0);
		t_write();
		t_read();
		t_irq();
		t_ce();
		t_cfg();
		t_role();
		print_verdict();
	end
endmodule
